// [core/uart_cfg_pkg.sv]
// Constants, register map and parity helper for the serial line block.
// Assumes a single 100 MHz clock and a 32-bit APB slave with 8-bit addresses.
package uart_cfg_pkg;
    localparam logic [7:0] OFF_LFC = 8'h00;
    localparam logic [7:0] OFF_MISC = 8'h04;
    localparam logic [7:0] OFF_BAUD = 8'h08;
    localparam logic [7:0] OFF_TXD = 8'h0c;
    localparam logic [7:0] OFF_RXD = 8'h10;
    localparam int B_LOOP = 7;
    localparam int B_SRC = 5;
    localparam int B_NINE = 4;
    localparam int B_IDLE_AFT = 2;
    localparam int B_PAR = 1;
    localparam int B_ODD = 0;
    localparam int B_INV = 0;
    localparam logic [7:0] LFC_RST = 8'h00;
    localparam logic [7:0] LFC_MASK = 8'hb7;
    localparam logic [15:0] BAUD_RST = 16'h0035;
    localparam logic [3:0] OS_MID = 4'h7;
    localparam logic [3:0] OS_LAST = 4'hf;
    localparam logic [3:0] LAST8 = 4'h9;
    localparam logic [3:0] LAST9 = 4'ha;
    localparam logic [3:0] IDLE8 = 4'ha;
    localparam logic [3:0] IDLE9 = 4'hb;

    // Parity bit that makes the character even (odd when odd is set)
    function automatic logic par_bit(logic [8:0] d, logic nine, logic odd);
        par_bit = (nine ? ^d[7:0] : ^d[6:0]) ^ odd;
    endfunction
endpackage

// [core/frame_if.sv]
// Link between the control top and its transmit and receive engines.
// Assumes all users sit on the same clock.
`timescale 1ns/1ps
interface frame_if;
    logic os_tick, nine, par_on, odd, idle_after_stop, tx_start, tx_busy, tx_bit;
    logic rx_in, rx_valid, rx_perr, rx_ferr, rx_idle;
    logic [8:0] tx_data, rx_data;
    modport ctl(output os_tick, nine, par_on, odd, idle_after_stop, tx_start, tx_data, rx_in,
                input tx_busy, tx_bit, rx_valid, rx_data, rx_perr, rx_ferr, rx_idle);
    modport tx(input os_tick, nine, par_on, odd, tx_start, tx_data, output tx_busy, tx_bit);
    modport rx(input os_tick, nine, par_on, odd, idle_after_stop, rx_in,
               output rx_valid, rx_data, rx_perr, rx_ferr, rx_idle);
endinterface

// [core/serial_tx.sv]
// Transmit shifter: start, data LSB first, optional ninth bit, stop.
// Assumes a 16x oversample tick; tx_start only while idle.
`timescale 1ns/1ps
module serial_tx
    import uart_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    frame_if.tx f
);
    typedef struct packed {
        logic busy;
        logic [3:0] os;
        logic [3:0] bitn;
        logic [10:0] sh;
    } tx_t;
    tx_t q, d;
    logic [8:0] dat;
    logic [3:0] last;

    assign last = f.nine ? LAST9 : LAST8;

    always_comb begin
        d = q;
        dat = f.tx_data;
        if (f.par_on && f.nine) begin
            dat[8] = par_bit(f.tx_data, 1'b1, f.odd);
        end else if (f.par_on) begin
            dat[7] = par_bit(f.tx_data, 1'b0, f.odd);
        end
        if (!q.busy && f.tx_start) begin
            d.busy = 1'b1;
            d.os = 4'h0;
            d.bitn = 4'h0;
            // Eight-bit frame pads with an extra stop-level bit that is never sent
            d.sh = f.nine ? {1'b1, dat, 1'b0} : {2'b11, dat[7:0], 1'b0};
        end else if (q.busy && f.os_tick) begin
            d.os = q.os + 4'h1;
            if (q.os == OS_LAST) begin
                d.sh = {1'b1, q.sh[10:1]};
                d.bitn = q.bitn + 4'h1;
                d.busy = (q.bitn != last);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign f.tx_busy = q.busy;
    assign f.tx_bit = q.busy ? q.sh[0] : 1'b1;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    len_eight_a: assert property (!f.nine && $fell(q.busy) |-> $past(q.bitn) == LAST8)
        else $error("eight-bit frame length wrong");
    len_nine_a: assert property (f.nine && $fell(q.busy) |-> $past(q.bitn) == LAST9)
        else $error("nine-bit frame length wrong");
    start_low_a: assert property ($rose(q.busy) |-> !f.tx_bit [*8])
        else $error("start bit not low");
    stop_high_a: assert property (q.busy && q.bitn == last |-> f.tx_bit)
        else $error("stop bit not high");
    par_gen_a: assert property ($rose(q.busy) && f.par_on |->
        ^(f.nine ? q.sh[9:1] : {1'b0, q.sh[8:1]}) == f.odd)
        else $error("transmit parity wrong");
endmodule // serial_tx

// [core/serial_rx.sv]
// Receive engine with mid-bit sampling, parity check and idle detection.
// Assumes rx_in already synchronised and a 16x oversample tick.
`timescale 1ns/1ps
module serial_rx
    import uart_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    frame_if.rx f
);
    typedef struct packed {
        logic act;
        logic [3:0] os;
        logic [3:0] bitn;
        logic [8:0] sh;
        logic valid;
        logic perr;
        logic ferr;
        logic [8:0] data;
        logic [3:0] ios;
        logic [3:0] icnt;
        logic idle;
    } rx_t;
    rx_t q, d;
    logic [3:0] last;
    logic [3:0] thr;
    logic [8:0] w;

    assign last = f.nine ? LAST9 : LAST8;
    assign thr = f.nine ? IDLE9 : IDLE8;

    always_comb begin
        d = q;
        d.valid = 1'b0;
        d.idle = 1'b0;
        w = f.nine ? q.sh : {1'b0, q.sh[8:1]};
        if (!q.act && !f.rx_in) begin
            d.act = 1'b1;
            d.os = 4'h0;
            d.bitn = 4'h0;
        end else if (q.act && f.os_tick) begin
            d.os = q.os + 4'h1;
            if (q.os == OS_MID) begin
                d.bitn = q.bitn + 4'h1;
                if (q.bitn == 4'h0) begin
                    d.act = !f.rx_in;
                end else if (q.bitn == last) begin
                    d.act = 1'b0;
                    d.valid = 1'b1;
                    d.data = w;
                    d.ferr = !f.rx_in;
                    d.perr = f.par_on && ((^w) != f.odd);
                end else begin
                    d.sh = {f.rx_in, q.sh[8:1]};
                end
            end
        end
        // Idle counting runs on its own bit phase so it works between frames
        if (f.os_tick) begin
            d.ios = q.ios + 4'h1;
        end
        // Held at zero for the whole frame, not just from the next bit boundary
        if (f.idle_after_stop && q.act) begin
            d.icnt = 4'h0;
        end else if (f.os_tick && q.ios == OS_LAST) begin
            if (!f.rx_in) begin
                d.icnt = 4'h0;
            end else if (q.icnt < thr) begin
                d.icnt = q.icnt + 4'h1;
                d.idle = (q.icnt == thr - 4'h1);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign f.rx_valid = q.valid;
    assign f.rx_data = q.data;
    assign f.rx_perr = q.perr;
    assign f.rx_ferr = q.ferr;
    assign f.rx_idle = q.idle;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    idle_count_a: assert property (q.idle |-> $past(q.icnt) == thr - 4'h1 && q.icnt == thr)
        else $error("idle reported at wrong count");
    idle_after_a: assert property (f.idle_after_stop && q.act |=> q.icnt == 4'h0)
        else $error("idle counted inside frame");
    par_check_a: assert property (q.valid && f.par_on && !q.perr |-> (^q.data) == f.odd)
        else $error("parity check wrong");
endmodule // serial_rx

// [core/uart_cfg_top.sv]
// Serial line block with APB registers, pin routing for normal,
// loopback and single-wire use, and frame format configuration.
// Assumes rxd and txd_i are asynchronous pins; APB is on mclk.
`timescale 1ns/1ps
module uart_cfg_top
    import uart_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    input wire logic txd_i,
    output logic txd_o,
    output logic txd_oe
);
    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        logic pin_s1;
        logic pin_s2;
        logic [7:0] lfc;
        logic inv;
        logic [15:0] baud;
        logic [15:0] div;
        logic os;
        logic txgo;
        logic [8:0] txdat;
        logic [8:0] rdat;
        logic f_valid;
        logic f_perr;
        logic f_ferr;
        logic f_idle;
        logic rdy;
        logic err;
        logic [31:0] rdata;
        logic txo;
        logic txoe;
    } top_t;
    top_t q, d;
    frame_if f();
    logic rise;
    logic acc;
    logic clr;
    logic loop;
    logic single;
    logic mapped;

    serial_tx serial_tx_inst (
        .mclk(mclk),
        .rst_b(rst_b),
        .f(f.tx)
    );

    serial_rx serial_rx_inst (
        .mclk(mclk),
        .rst_b(rst_b),
        .f(f.rx)
    );

    assign loop = q.lfc[B_LOOP];
    assign single = loop && q.lfc[B_SRC];
    assign rise = psel && penable && !q.rdy;
    assign acc = psel && penable && q.rdy;
    // Clear at the edge that captures the status, so nothing arriving later is lost unseen
    assign clr = rise && !pwrite && paddr == OFF_RXD;
    assign mapped = paddr == OFF_LFC || paddr == OFF_MISC || paddr == OFF_BAUD ||
                    paddr == OFF_TXD || paddr == OFF_RXD;

    assign f.os_tick = q.os;
    assign f.nine = q.lfc[B_NINE];
    assign f.par_on = q.lfc[B_PAR];
    assign f.odd = q.lfc[B_ODD];
    assign f.idle_after_stop = q.lfc[B_IDLE_AFT];
    assign f.tx_start = q.txgo;
    assign f.tx_data = q.txdat;

    // Receiver source: source bit only counts once loop select is set
    always_comb begin
        if (!loop) begin
            f.rx_in = q.rx_s2;
        end else if (q.lfc[B_SRC]) begin
            f.rx_in = q.pin_s2;
        end else begin
            f.rx_in = f.tx_bit;
        end
    end

    always_comb begin
        d = q;
        d.rx_s1 = rxd;
        d.rx_s2 = q.rx_s1;
        d.pin_s1 = txd_i;
        d.pin_s2 = q.pin_s1;
        d.txgo = 1'b0;
        if (q.div == 16'h0000) begin
            d.div = q.baud;
            d.os = 1'b1;
        end else begin
            d.div = q.div - 16'h0001;
            d.os = 1'b0;
        end
        // New events win over a read that clears in the same cycle
        d.f_valid = f.rx_valid || (q.f_valid && !clr);
        d.f_perr = (f.rx_valid && f.rx_perr) || (q.f_perr && !clr);
        d.f_ferr = (f.rx_valid && f.rx_ferr) || (q.f_ferr && !clr);
        d.f_idle = f.rx_idle || (q.f_idle && !clr);
        if (f.rx_valid) begin
            d.rdat = f.rx_data;
        end
        d.rdy = rise;
        d.err = 1'b0;
        if (rise) begin
            d.err = !mapped || (pwrite && paddr == OFF_TXD && (f.tx_busy || q.txgo));
            case (paddr)
                OFF_LFC: begin
                    d.rdata = {24'h000000, q.lfc};
                end
                OFF_MISC: begin
                    d.rdata = {31'h0, q.inv};
                end
                OFF_BAUD: begin
                    d.rdata = {16'h0000, q.baud};
                end
                OFF_RXD: begin
                    d.rdata = {18'h0, f.tx_busy, q.f_idle, q.f_ferr, q.f_perr, q.f_valid, q.rdat};
                end
                default: begin
                    d.rdata = 32'h00000000;
                end
            endcase
        end
        if (acc && pwrite && !q.err) begin
            case (paddr)
                OFF_LFC: begin
                    d.lfc = pwdata[7:0] & LFC_MASK;
                end
                OFF_MISC: begin
                    d.inv = pwdata[B_INV];
                end
                OFF_BAUD: begin
                    d.baud = pwdata[15:0];
                    d.div = pwdata[15:0];
                end
                OFF_TXD: begin
                    d.txgo = 1'b1;
                    d.txdat = pwdata[8:0];
                end
                default: begin
                    d.txgo = 1'b0;
                end
            endcase
        end
        d.txo = f.tx_bit ^ q.inv;
        // Single wire releases the shared pin whenever nothing is being sent
        d.txoe = !single || f.tx_busy;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
            q.lfc <= LFC_RST;
            q.baud <= BAUD_RST;
            q.rx_s1 <= 1'b1;
            q.rx_s2 <= 1'b1;
            q.pin_s1 <= 1'b1;
            q.pin_s2 <= 1'b1;
            q.txo <= 1'b1;
            q.txoe <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.rdata;
    assign pready = q.rdy;
    assign pslverr = q.err;
    assign txd_o = q.txo;
    assign txd_oe = q.txoe;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    wrap_route_a: assert property (loop && !q.lfc[B_SRC] |-> f.rx_in == f.tx_bit)
        else $error("loopback does not feed receiver");

    normal_pins_a: assert property (!loop |-> f.rx_in == q.rx_s2)
        else $error("normal mode not using receive pin");

    pin_ignored_a: assert property (loop && $changed(q.rx_s2) && $stable(q.pin_s2) &&
        $stable(f.tx_bit) && $stable(q.lfc) |-> $stable(f.rx_in))
        else $error("receive pin leaks in loop mode");

    src_no_effect_a: assert property (!loop && $stable(loop) && $changed(q.lfc[B_SRC]) &&
        $stable(q.rx_s2) |-> $stable(f.rx_in))
        else $error("source bit acts without loop");

    wrap_frame_a: assert property (loop && !q.lfc[B_SRC] && $rose(f.tx_busy) &&
        $stable(q.lfc) |-> !f.rx_in [*8])
        else $error("start bit not looped back");

    single_drive_a: assert property (single && f.tx_busy |=> txd_oe &&
        f.rx_in == q.pin_s2)
        else $error("single wire not driving pin");

    single_rel_a: assert property (single && !f.tx_busy ##1 single && !f.tx_busy |-> !txd_oe)
        else $error("single wire pin not released");

    idle_high_a: assert property ((!f.tx_busy && !q.inv) [*2] |-> txd_o)
        else $error("transmit line not idle high");

    idle_inv_a: assert property ((!f.tx_busy && q.inv) [*2] |-> !txd_o)
        else $error("inverted idle not low");

    reset_clear_a: assert property ($rose(rst_b) |-> q.lfc == LFC_RST && txd_o)
        else $error("control not clear after reset");

    lfc_write_a: assert property (acc && pwrite && !q.err && paddr == OFF_LFC |=>
        q.lfc == ($past(pwdata[7:0]) & LFC_MASK))
        else $error("line control write lost");

    apb_wait_a: assert property (rise |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

    flag_keep_a: assert property (f.rx_valid |=> q.f_valid)
        else $error("receive event lost");

    loop_rx_c: cover property (loop && !q.lfc[B_SRC] && f.rx_valid);
    single_rx_c: cover property (single && f.rx_valid);
    par_err_c: cover property (f.par_on && f.rx_valid && f.rx_perr);
    idle_c: cover property (f.rx_idle && f.idle_after_stop);
endmodule // uart_cfg_top

// [sim/serial_peer.sv]
// Remote serial node: sends frames on the receive pin or on the shared transmit pin,
// and decodes frames seen on the transmit pin.
// Assumes the bench programs a bit time of BT clocks and puts a pull-up on the transmit pin.
`timescale 1ns/1ps
module serial_peer #(
    parameter int BT = 16
) (
    input wire logic mclk,
    input wire logic pin_lvl,
    output logic rxd_drv,
    output logic pin_o,
    output logic pin_oe
);
    initial begin
        rxd_drv = 1'b1;
        pin_o = 1'b1;
        pin_oe = 1'b0;
    end

    // Hold the receive pin at a level, used to jam it while it must be ignored
    task automatic jam(input logic v);
        @(posedge mclk);
        rxd_drv <= v;
    endtask

    // Start low, data LSB first, optional ninth bit, stop
    task automatic send(input logic on_pin, input logic [8:0] d, input int n, input logic stop);
        logic b;
        for (int i = 0; i < n + 2; i++) begin
            b = (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : stop;
            @(posedge mclk);
            if (on_pin) begin
                pin_oe <= 1'b1;
                pin_o <= b;
            end else begin
                rxd_drv <= b;
            end
            repeat (BT - 1) @(posedge mclk);
        end
        // Released pin floats to the pull-up
        @(posedge mclk);
        pin_oe <= 1'b0;
        rxd_drv <= 1'b1;
    endtask

    // Mid-bit sampling; ok is low on a lost start, bad start or low stop
    task automatic recv(input int n, output logic [8:0] d, output logic ok);
        int w;
        w = 0;
        d = 9'h000;
        ok = 1'b0;
        while (pin_lvl !== 1'b0 && w < 400) begin
            @(posedge mclk);
            w++;
        end
        if (w < 400) begin
            repeat (BT / 2) @(posedge mclk);
            ok = (pin_lvl === 1'b0);
            for (int i = 0; i < n; i++) begin
                repeat (BT) @(posedge mclk);
                d[i] = pin_lvl;
            end
            repeat (BT) @(posedge mclk);
            ok = ok && (pin_lvl === 1'b1);
        end
    endtask
endmodule // serial_peer

// [sim/uart_frame_and_loop_config_bench.sv]
// Self-checking bench for the serial line block: registers over APB, frame formats,
// parity, idle detection and the normal, loopback and single-wire pin routing.
// Assumes the baud register is set to 0, giving a bit time of 16 clocks.
`timescale 1ns/1ps
module uart_frame_and_loop_config_bench;
    import uart_cfg_pkg::*;
    localparam int BT = 16;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, txd_o, txd_oe, rxd, pin_o, pin_oe;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int bad_count, cmp_count, cyc;
    // Transmit pin: design wins, then the peer, else the pull-up
    wire logic pin_lvl = txd_oe ? txd_o : (pin_oe ? pin_o : 1'b1);

    uart_cfg_top uart_cfg_top_inst (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd_i(pin_lvl), .txd_o(txd_o), .txd_oe(txd_oe));
    serial_peer #(.BT(BT)) serial_peer_inst (.mclk(mclk), .pin_lvl(pin_lvl), .rxd_drv(rxd),
        .pin_o(pin_o), .pin_oe(pin_oe));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic conclude();
        if (bad_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Ceiling well above the roughly 3000 cycles the scenarios need
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One idle cycle between transfers keeps every strobe to one assignment per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) chk("pready wait", 32'h1, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk("write error", 32'h0, {31'h0, e});
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk("read error", 32'h0, {31'h0, e});
    endtask

    function automatic logic exp_par(input logic [8:0] v, input int n, input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < n - 1; i++) p ^= v[i];
        return p;
    endfunction

    task automatic t_reset();
        logic [31:0] r;
        logic e;
        chk("txd_o idle", 32'h1, {31'h0, txd_o});
        chk("txd_oe idle", 32'h1, {31'h0, txd_oe});
        rd(OFF_LFC, r);
        chk("line control reset", {24'h0, LFC_RST}, r);
        rd(OFF_MISC, r);
        chk("misc reset", 32'h0, r);
        wr(OFF_LFC, 32'hffff_ffff);
        rd(OFF_LFC, r);
        chk("line control mask", {24'h0, LFC_MASK}, r);
        apb(1'b0, 8'h1c, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        rd(OFF_BAUD, r);
        chk("baud reset", {16'h0, BAUD_RST}, r);
        wr(OFF_BAUD, 32'h0);
    endtask

    task automatic t_format();
        logic [7:0] cfg [6];
        logic [8:0] d, e, got;
        logic ok;
        int n;
        cfg = '{8'h00, 8'h10, 8'h02, 8'h03, 8'h12, 8'h13};
        for (int i = 0; i < 6; i++) begin
            d = i[0] ? 9'h0ac : 9'h153;
            n = cfg[i][4] ? 9 : 8;
            e = cfg[i][4] ? d : {1'b0, d[7:0]};
            if (cfg[i][1]) e[n-1] = exp_par(e, n, cfg[i][0]);
            wr(OFF_LFC, {24'h0, cfg[i]});
            wr(OFF_TXD, {23'h0, d});
            serial_peer_inst.recv(n, got, ok);
            chk("tx framing", 32'h1, {31'h0, ok});
            chk("tx data", {23'h0, e}, {23'h0, got});
            repeat (BT) @(posedge mclk);
        end
    endtask

    task automatic t_rx();
        logic [31:0] st;
        logic p;
        wr(OFF_LFC, 32'h20);
        serial_peer_inst.send(1'b0, 9'h03c, 8, 1'b1);
        rd(OFF_RXD, st);
        chk("rx normal", 32'h23c, {20'h0, st[11:0]});
        repeat (5 * BT) @(posedge mclk);
        rd(OFF_RXD, st);
        chk("idle early", 32'h0, {31'h0, st[12]});
        repeat (8 * BT) @(posedge mclk);
        rd(OFF_RXD, st);
        chk("idle seen", 32'h1, {31'h0, st[12]});
        wr(OFF_LFC, 32'h17);
        p = exp_par(9'h05b, 9, 1'b1);
        serial_peer_inst.send(1'b0, {p, 8'h5b}, 9, 1'b1);
        rd(OFF_RXD, st);
        chk("rx parity good", {20'h0, 3'b001, p, 8'h5b}, {20'h0, st[11:0]});
        serial_peer_inst.send(1'b0, {~p, 8'h5b}, 9, 1'b1);
        rd(OFF_RXD, st);
        chk("rx parity bad", 32'h1, {31'h0, st[10]});
        serial_peer_inst.send(1'b0, 9'h0f0, 9, 1'b0);
        rd(OFF_RXD, st);
        chk("rx stop low", 32'h1, {31'h0, st[11]});
    endtask

    // Poll status until a character arrives; the design answers within one frame
    task automatic wait_rx(output logic [31:0] st);
        int n;
        n = 0;
        do begin
            rd(OFF_RXD, st);
            n++;
        end while (st[9] !== 1'b1 && n < 60);
    endtask

    task automatic t_loop();
        logic [31:0] st, r;
        logic e;
        wr(OFF_LFC, 32'h80);
        serial_peer_inst.jam(1'b0);
        wr(OFF_TXD, 32'h05a);
        // Second character while the first is still shifting must be refused and dropped
        apb(1'b1, OFF_TXD, 32'h0ff, r, e);
        chk("busy write refused", 32'h1, {31'h0, e});
        wait_rx(st);
        chk("internal loop", 32'h25a, {20'h0, st[11:0]});
        serial_peer_inst.jam(1'b1);
    endtask

    task automatic t_single();
        logic [31:0] st;
        logic [8:0] got;
        logic ok;
        wr(OFF_LFC, 32'ha0);
        repeat (3) @(posedge mclk);
        chk("single wire released", 32'h0, {31'h0, txd_oe});
        serial_peer_inst.jam(1'b0);
        serial_peer_inst.send(1'b1, 9'h096, 8, 1'b1);
        rd(OFF_RXD, st);
        chk("single wire rx", 32'h296, {20'h0, st[11:0]});
        wr(OFF_TXD, 32'h041);
        serial_peer_inst.recv(8, got, ok);
        chk("single wire tx", 32'h141, {23'h0, ok, got[7:0]});
        repeat (BT) @(posedge mclk);
        rd(OFF_RXD, st);
        chk("single wire echo", 32'h241, {20'h0, st[11:0]});
        serial_peer_inst.jam(1'b1);
    endtask

    task automatic t_invert();
        wr(OFF_LFC, 32'h0);
        wr(OFF_MISC, 32'h1);
        repeat (3) @(posedge mclk);
        chk("inverted idle", 32'h0, {31'h0, txd_o});
        wr(OFF_MISC, 32'h0);
        repeat (3) @(posedge mclk);
        chk("plain idle", 32'h1, {31'h0, txd_o});
    endtask

    initial begin
        bad_count = 0;
        cmp_count = 0;
        cyc = 0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_format();
        t_rx();
        t_loop();
        t_single();
        t_invert();
        conclude();
    end
endmodule // uart_frame_and_loop_config_bench
